/* shared/ramp_regs.vh */
// register map, reset values and timing constants of the analog ramp generator
// Functional notes
// - enable rise: start/stop level 200 ms, then ramp
// - enable fall: level to offset at once
// - select 0 picks level one, 1 level two
// - select change ramps from present level
// - stop rise: ramp down, hold, then offset
// - current level never exceeds ceiling; after a ceiling write the level can stay above it for up to two ticks
// - start/stop level is offset plus start offset
// - rate in steps per second, 1..10000
// - output is (level-offset)/gain, clamped 0..32767
// - level recomputed once per 100 ms tick
// - after stop, restart needs stop and enable low
`ifndef RAMP_REGS_VH
`define RAMP_REGS_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFS_TARGET_ONE    12'h000
`define OFS_TARGET_TWO    12'h004
`define OFS_CEILING       12'h008
`define OFS_START_OFFSET  12'h00c
`define OFS_RATE          12'h010
`define OFS_GAIN          12'h014
`define OFS_LEVEL_OFFSET  12'h018
`define OFS_CUR_LEVEL     12'h01c
`define OFS_STATUS        12'h020

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_TARGET        16'h0000
`define RST_CEILING       16'h4e20
`define RST_START_OFFSET  15'h0000
`define RST_RATE          14'h0001
`define RST_GAIN          10'h064
`define RST_LEVEL_OFFSET  16'h0000

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_MHZ           200
`define TICK_MS           100
`define TICK_CYCLES       (`TICK_MS * `CLK_MHZ * 1000)
`define TICKS_PER_SEC     (1000 / `TICK_MS)
`define GAIN_SCALE        100
`define OUT_MAX           15'h7fff

`endif

/* hw/ramp_scale.v */
// scaled output stage: (level - offset) / gain with clamp
`timescale 1ns/1ps
`include "ramp_regs.vh"
module ramp_scale (
    input  wire               pclk,
    input  wire               presetn,
    input  wire signed [17:0] level,
    input  wire signed [17:0] offset,
    input  wire        [9:0]  gain,
    output reg         [14:0] scaled
);
    // ------------------------------------------------------------------
    // arithmetic
    // ------------------------------------------------------------------
    // gain is held in hundredths, so the difference is scaled by 100 first
    wire signed [18:0] diff   = {level[17], level} - {offset[17], offset};
    wire signed [26:0] num    = diff * 27'sd100;
    wire        [26:0] quo    = $unsigned(num) / {17'h00000, gain};
    reg         [14:0] scaled_nxt;

    always @* begin
        if (diff <= 19'sd0) begin
            scaled_nxt = 15'h0000;
        end else if (gain == 10'h000) begin
            scaled_nxt = `OUT_MAX;                          // divide by zero saturates
        end else if (quo > {12'h000, `OUT_MAX}) begin
            scaled_nxt = `OUT_MAX;
        end else begin
            scaled_nxt = quo[14:0];
        end
    end

    // registered so the output is a clean flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scaled <= 15'h0000;
        end else begin
            scaled <= scaled_nxt;
        end
    end
endmodule // ramp_scale

/* hw/ramp_gen.v */
// analog ramp generator with apb configuration registers
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "ramp_regs.vh"
module ramp_gen #(
    parameter TICK_CYCLES = `TICK_CYCLES
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire        enable,
    input  wire        level_select,
    input  wire        decel_stop,
    output wire [14:0] scaled_output,
    output wire [17:0] current_level
);
    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_START = 3'd1;
    localparam [2:0] ST_RAMP  = 3'd2;
    localparam [2:0] ST_DECEL = 3'd3;
    localparam [2:0] ST_HOLD  = 3'd4;
    localparam [2:0] ST_LOCK  = 3'd5;
    localparam integer TICK_LAST_I = TICK_CYCLES - 1;
    // tick counter is 25 bits, enough for 100 ms at 200 MHz
    localparam [24:0] TICK_LAST = TICK_LAST_I[24:0];

    reg        [15:0] target_one_r;
    reg        [15:0] target_two_r;
    reg        [15:0] ceiling_r;
    reg        [14:0] start_offset_r;
    reg        [13:0] rate_r;
    reg        [9:0]  gain_r;
    reg        [15:0] level_offset_r;
    reg signed [17:0] level_r;
    reg        [2:0]  state_r;
    reg        [3:0]  frac_r;
    reg        [24:0] tick_cnt_r;
    reg               tick_r;
    reg               en_prev_r;
    reg               stop_prev_r;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // signed 16-bit register to 18-bit working width
    function signed [17:0] sx16;
        input [15:0] v;
        begin
            sx16 = {{2{v[15]}}, v};
        end
    endfunction

    // never let any level pass the ceiling
    function signed [17:0] clamp_ceil;
        input signed [17:0] v;
        input signed [17:0] c;
        begin
            clamp_ceil = (v > c) ? c : v;
        end
    endfunction

    // one step toward the goal without overshooting it
    function signed [17:0] move_to;
        input signed [17:0] cur;
        input signed [17:0] tgt;
        input        [9:0]  step;
        reg   signed [17:0] s;
        begin
            s = {8'h00, step};
            if (cur < tgt) begin
                move_to = (tgt - cur > s) ? cur + s : tgt;
            end else begin
                move_to = (cur - tgt > s) ? cur - s : tgt;
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // derived levels
    // ------------------------------------------------------------------
    wire signed [17:0] ceil_lvl  = sx16(ceiling_r);
    wire signed [17:0] base_lvl  = clamp_ceil(sx16(level_offset_r), ceil_lvl);
    wire signed [17:0] ss_lvl    = clamp_ceil(sx16(level_offset_r) + {3'b000, start_offset_r}, ceil_lvl);
    wire signed [17:0] tgt_lvl   = clamp_ceil(level_select ? sx16(target_two_r) : sx16(target_one_r),
                                              ceil_lvl);
    // rate is per second; carry the remainder so slow rates still move
    wire        [13:0] rate_sum  = rate_r + {10'h000, frac_r};
    wire        [13:0] step_full = rate_sum / 14'd10;
    wire        [13:0] frac_full = rate_sum % 14'd10;
    wire        [9:0]  step      = step_full[9:0];
    wire               en_rise   = enable & ~en_prev_r;
    wire               stop_rise = decel_stop & ~stop_prev_r;

    // ------------------------------------------------------------------
    // 100 ms update tick
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_r <= 25'h0000000;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r == TICK_LAST) begin
            tick_cnt_r <= 25'h0000000;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 25'h0000001;
            tick_r     <= 1'b0;
        end
    end

    // inputs come from logic on this clock; edges are judged per tick
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_prev_r   <= 1'b0;
            stop_prev_r <= 1'b0;
        end else if (tick_r) begin
            en_prev_r   <= enable;
            stop_prev_r <= decel_stop;
        end
    end

    // ------------------------------------------------------------------
    // ramp state machine
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            level_r <= 18'sd0;
            frac_r  <= 4'h0;
        end else if (!enable) begin
            // dropping enable acts at once, not on the tick
            level_r <= base_lvl;
            frac_r  <= 4'h0;
            state_r <= (state_r == ST_LOCK && decel_stop) ? ST_LOCK : ST_IDLE;
        end else if (tick_r) begin
            case (state_r)
                ST_IDLE: begin
                    level_r <= base_lvl;
                    if (en_rise && !decel_stop) begin
                        level_r <= ss_lvl;
                        state_r <= ST_START;
                    end
                end
                ST_START: begin
                    // one full tick spent at the start/stop level
                    state_r <= stop_rise ? ST_DECEL : ST_RAMP;
                    level_r <= clamp_ceil(level_r, ceil_lvl);
                end
                ST_RAMP: begin
                    frac_r <= frac_full[3:0];
                    if (stop_rise) begin
                        state_r <= ST_DECEL;
                    end else begin
                        // goal follows select, so a change just redirects
                        level_r <= clamp_ceil(move_to(level_r, tgt_lvl, step), ceil_lvl);
                    end
                end
                ST_DECEL: begin
                    frac_r  <= frac_full[3:0];
                    level_r <= clamp_ceil(move_to(level_r, ss_lvl, step), ceil_lvl);
                    if (move_to(level_r, ss_lvl, step) == ss_lvl) begin
                        state_r <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    level_r <= base_lvl;
                    state_r <= ST_LOCK;
                end
                ST_LOCK: begin
                    level_r <= base_lvl;
                end
                default: begin
                    state_r <= ST_IDLE;
                    level_r <= base_lvl;
                end
            endcase
        end
    end

    assign current_level = level_r;

    // ------------------------------------------------------------------
    // scaled output
    // ------------------------------------------------------------------
    ramp_scale u_scale (
        .pclk    (pclk),
        .presetn (presetn),
        .level   (level_r),
        .offset  (sx16(level_offset_r)),
        .gain    (gain_r),
        .scaled  (scaled_output)
    );

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    wire acc     = psel & penable;
    wire wr      = acc & pwrite;
    wire mapped  = (paddr == `OFS_TARGET_ONE) || (paddr == `OFS_TARGET_TWO) ||
                   (paddr == `OFS_CEILING) || (paddr == `OFS_START_OFFSET) ||
                   (paddr == `OFS_RATE) || (paddr == `OFS_GAIN) ||
                   (paddr == `OFS_LEVEL_OFFSET) || (paddr == `OFS_CUR_LEVEL) ||
                   (paddr == `OFS_STATUS);
    reg  [31:0] rd_nxt;

    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    // configuration writes; rate below one is forced to one
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_one_r   <= `RST_TARGET;
            target_two_r   <= `RST_TARGET;
            ceiling_r      <= `RST_CEILING;
            start_offset_r <= `RST_START_OFFSET;
            rate_r         <= `RST_RATE;
            gain_r         <= `RST_GAIN;
            level_offset_r <= `RST_LEVEL_OFFSET;
        end else if (wr) begin
            case (paddr)
                `OFS_TARGET_ONE:   target_one_r   <= pwdata[15:0];
                `OFS_TARGET_TWO:   target_two_r   <= pwdata[15:0];
                `OFS_CEILING:      ceiling_r      <= pwdata[15:0];
                `OFS_START_OFFSET: start_offset_r <= pwdata[14:0];
                `OFS_RATE:         rate_r         <= (pwdata[13:0] == 14'h0000) ? 14'h0001 : pwdata[13:0];
                `OFS_GAIN:         gain_r         <= pwdata[9:0];
                `OFS_LEVEL_OFFSET: level_offset_r <= pwdata[15:0];
                default:           ;
            endcase
        end
    end

    // read mux; level fields are sign-extended to 32 bits
    always @* begin
        case (paddr)
            `OFS_TARGET_ONE:   rd_nxt = {{16{target_one_r[15]}}, target_one_r};
            `OFS_TARGET_TWO:   rd_nxt = {{16{target_two_r[15]}}, target_two_r};
            `OFS_CEILING:      rd_nxt = {{16{ceiling_r[15]}}, ceiling_r};
            `OFS_START_OFFSET: rd_nxt = {17'h00000, start_offset_r};
            `OFS_RATE:         rd_nxt = {18'h00000, rate_r};
            `OFS_GAIN:         rd_nxt = {22'h000000, gain_r};
            `OFS_LEVEL_OFFSET: rd_nxt = {{16{level_offset_r[15]}}, level_offset_r};
            `OFS_CUR_LEVEL:    rd_nxt = {{14{level_r[17]}}, level_r};
            `OFS_STATUS:       rd_nxt = {13'h0000, state_r, 1'b0, scaled_output};
            default:           rd_nxt = 32'h00000000;
        endcase
    end

    // captured in the setup cycle, stable through the access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_nxt;
        end
    end
endmodule // ramp_gen

/* tb/ramp_chk.sv */
// port-level checks of the ramp generator
`timescale 1ns/1ps
module ramp_chk #(
    parameter TICK_CYCLES = 20
) (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire [31:0] prdata,
    input wire        pslverr,
    input wire        enable,
    input wire        level_select,
    input wire        decel_stop,
    input wire [14:0] scaled_output,
    input wire [17:0] current_level
);
    wire               acc = psel && penable;
    wire               wr  = acc && pwrite;
    wire               hit = (paddr[1:0] == 2'b00) && (paddr <= 12'h020);
    wire signed [17:0] lvl = current_level;
    reg  signed [17:0] off_r;
    reg  signed [17:0] ceil_r;
    reg         [9:0]  gain_r;
    reg         [31:0] quiet_r;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // shadow config; ceiling check waits two ticks after a write so the level can follow
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            off_r   <= 18'sh0;
            ceil_r  <= 18'sd20000;
            gain_r  <= 10'h064;
            quiet_r <= 32'h0;
        end else begin
            if (wr && paddr == 12'h018) off_r <= {{2{pwdata[15]}}, pwdata[15:0]};
            if (wr && paddr == 12'h014) gain_r <= pwdata[9:0];
            if (wr && paddr == 12'h008) begin
                ceil_r  <= {{2{pwdata[15]}}, pwdata[15:0]};
                quiet_r <= 32'h0;
            end else if (quiet_r != 32'hffffffff) quiet_r <= quiet_r + 32'h1;
        end
    end
    chk_ready_fixed: assert property (acc |-> pready) else $error("pready low in access");
    chk_err_unmapped: assert property (acc && !hit |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    chk_err_mapped: assert property (acc && hit |-> !pslverr) else $error("mapped access refused");
    chk_ceil_read: assert property (acc && !pwrite && paddr == 12'h008 |-> prdata[15:0] == ceil_r[15:0])
        else $error("ceiling readback wrong");
    chk_lvl_read: assert property (acc && !pwrite && paddr == 12'h01c |-> prdata[17:0] == $past(current_level))
        else $error("level readback wrong");
    chk_drop_offset: assert property (
        !enable && !(wr && paddr == 12'h018) |=> lvl == off_r) else $error("enable low, level not offset");
    chk_ceiling_held: assert property (
        quiet_r >= 2 * TICK_CYCLES |-> lvl <= ceil_r) else $error("level above ceiling");
    chk_scale_unity: assert property (
        gain_r == 10'h064 && off_r == 18'sh0
        |=> scaled_output == ($past(lvl) < 0 ? 15'h0 : $past(current_level[14:0])))
        else $error("scaled output wrong at unity gain");
    chk_tick_spacing: assert property (
        $changed(current_level) && $past(enable) |=> !$past(enable) || $stable(current_level))
        else $error("level moved on consecutive cycles");
endmodule // ramp_chk
bind ramp_gen ramp_chk #(.TICK_CYCLES(TICK_CYCLES)) ramp_chk_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .enable(enable), .level_select(level_select),
    .decel_stop(decel_stop), .scaled_output(scaled_output), .current_level(current_level));

/* tb/ctl_partner.sv */
// stand-in for the program logic driving the ramp control inputs
`timescale 1ns/1ps
module ctl_partner (
    input  wire pclk,
    input  wire presetn,
    input  wire run_req,
    input  wire sel_req,
    input  wire stop_req,
    output reg  enable_r,
    output reg  sel_r,
    output reg  stop_r
);
    // plain levels, held until asked to move, so every change spans a tick boundary
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_r <= 1'b0;
            sel_r    <= 1'b0;
            stop_r   <= 1'b0;
        end else begin
            enable_r <= run_req;
            sel_r    <= sel_req;
            stop_r   <= stop_req;
        end
    end
endmodule // ctl_partner

/* tb/tb.sv */
// self-checking testbench of the ramp generator
`timescale 1ns/1ps
`include "ramp_regs.vh"
module tb;
    localparam TK = 20;
    reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0, q;
    reg         run_req = 1'b0, sel_req = 1'b0, stop_req = 1'b0, e;
    wire        pready, pslverr, enable, level_select, decel_stop;
    wire [31:0] prdata;
    wire [14:0] scaled_output;
    wire [17:0] current_level;
    integer     failures = 0, num_checks = 0, seed = 32'h3163, i;
    reg  signed [17:0] t, o;
    reg  [9:0]  g;
    always #2.5 pclk = ~pclk;
    ramp_gen #(.TICK_CYCLES(TK)) ramp_gen_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .enable(enable), .level_select(level_select),
        .decel_stop(decel_stop), .scaled_output(scaled_output), .current_level(current_level));
    ctl_partner ctl_partner_inst (.pclk(pclk), .presetn(presetn), .run_req(run_req), .sel_req(sel_req),
        .stop_req(stop_req), .enable_r(enable), .sel_r(level_select), .stop_r(decel_stop));
    task close_out;
        begin
            $display("checks %0d mismatches %0d", num_checks, failures);
            if (failures == 0 && num_checks > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp, input [8*8:1] what);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("FAIL %0s expected %0h seen %0h", what, exp, seen);
            end
        end
    endtask
    // one apb transfer; result left in q and e
    task apb(input [11:0] a, input w, input [31:0] d);
        integer n;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            @(posedge pclk);
            while (pready !== 1'b1) begin
                n = n + 1;
                if (n > 50) begin
                    failures = failures + 1;
                    close_out;
                end
                @(posedge pclk);
            end
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task cyc(input integer n);
        begin
            repeat (n) @(posedge pclk);
            #1;
        end
    endtask
    // while enable is high levels move on ticks only, so a bounded poll is the honest wait
    task wait_lvl(input signed [17:0] v, input integer lim);
        integer n;
        begin
            n = 0;
            #1;
            while ($signed(current_level) !== v) begin
                n = n + 1;
                if (n > lim) begin
                    failures = failures + 1;
                    close_out;
                end
                cyc(1);
            end
        end
    endtask
    function [14:0] exp_scaled(input signed [17:0] l, input signed [17:0] off, input [9:0] gn);
        integer r;
        begin
            r = ((l - off) * 100) / $signed({1'b0, gn});
            exp_scaled = (r < 0) ? 15'h0 : (r > 32767) ? 15'h7fff : r[14:0];
        end
    endfunction
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // reset values and refused accesses
        apb(`OFS_CEILING, 0, 0);
        chk(q[15:0], `RST_CEILING, "ceiling");
        apb(`OFS_GAIN, 0, 0);
        chk(q[9:0], `RST_GAIN, "gain");
        apb(12'h024, 0, 0);
        chk(e, 1'b1, "unmapped");
        chk(q, 32'h00000000, "unm_data");
        apb(12'h002, 1, 5);
        chk(e, 1'b1, "misalign");
        apb(`OFS_CUR_LEVEL, 1, 77);
        apb(`OFS_CUR_LEVEL, 0, 0);
        chk(q[17:0], 0, "lvl_ro");
        apb(`OFS_RATE, 1, 0);
        apb(`OFS_RATE, 0, 0);
        chk(q[13:0], 1, "rate0");
        apb(`OFS_TARGET_ONE, 1, 500);
        apb(`OFS_TARGET_TWO, 1, 300);
        apb(`OFS_START_OFFSET, 1, 100);
        apb(`OFS_RATE, 1, 1000);
        // start level for two ticks, then 100 per tick toward target one
        run_req <= 1'b1;
        wait_lvl(100, 3 * TK);
        chk(current_level, 100, "start");
        cyc(TK + TK / 2);
        chk(current_level, 100, "hold");
        cyc(TK);
        chk(current_level, 200, "step");
        wait_lvl(500, 5 * TK);
        cyc(2 * TK);
        chk(current_level, 500, "target1");
        chk(scaled_output, exp_scaled(500, 0, 100), "scaled");
        sel_req <= 1'b1;
        wait_lvl(400, 3 * TK);
        chk(current_level, 400, "reselect");
        wait_lvl(300, 3 * TK);
        cyc(2 * TK);
        chk(current_level, 300, "target2");
        // decelerated stop; output lags the level by one clock
        stop_req <= 1'b1;
        wait_lvl(100, 5 * TK);
        cyc(TK / 2);
        chk(current_level, 100, "decel");
        wait_lvl(0, 3 * TK);
        cyc(2);
        chk(scaled_output, 0, "stopped");
        // a restart tried while stop is still high must stay locked
        run_req <= 1'b0;
        cyc(2 * TK);
        run_req <= 1'b1;
        cyc(3 * TK);
        chk(current_level, 0, "retry");
        stop_req <= 1'b0;
        cyc(3 * TK);
        chk(current_level, 0, "locked");
        apb(`OFS_STATUS, 0, 0);
        chk(q, 32'h00050000, "status");
        run_req <= 1'b0;
        cyc(2 * TK);
        run_req <= 1'b1;
        wait_lvl(100, 3 * TK);
        cyc(2 * TK + TK / 2);
        chk(current_level, 200, "restart");
        run_req <= 1'b0;
        cyc(3);
        chk(current_level, 0, "drop");
        // ceiling caps the chosen target
        apb(`OFS_CEILING, 1, 250);
        sel_req <= 1'b0;
        cyc(2 * TK);
        run_req <= 1'b1;
        wait_lvl(250, 6 * TK);
        cyc(3 * TK);
        chk(current_level, 250, "ceiling");
        run_req <= 1'b0;
        cyc(2 * TK);
        apb(`OFS_CEILING, 1, 20000);
        // random targets, offsets, gains and rates
        for (i = 0; i < 4; i = i + 1) begin
            t = 200 + $unsigned($random(seed)) % 1800;
            o = ($unsigned($random(seed)) % 201) - 100;
            g = 50 + $unsigned($random(seed)) % 350;
            apb(`OFS_TARGET_ONE, 1, t);
            apb(`OFS_LEVEL_OFFSET, 1, {{14{o[17]}}, o});
            apb(`OFS_GAIN, 1, g);
            apb(`OFS_RATE, 1, 1000 + $unsigned($random(seed)) % 9001);
            run_req <= 1'b1;
            wait_lvl(t, 25 * TK);
            cyc(2);
            chk(scaled_output, exp_scaled(t, o, g), "scaled");
            run_req <= 1'b0;
            cyc(3);
            chk(current_level, o[17:0], "offset");
            cyc(2 * TK);
        end
        close_out;
    end
endmodule // tb
